// *** core/epdo_pkg.sv ***
// Purpose: shared constants, types and helpers of the encoder pulse divider output
// Assumes: 100 MHz core clock, 16-bit register port with word addresses
// Notes: long counts are re-exposed as top-level parameters
package epdo_pkg;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned ACC_W        = 24;
  localparam int unsigned TMR_W        = 20;
  localparam int unsigned IRQ_W        = 4;
  // register word addresses
  localparam logic [3:0]  OFS_SOURCE   = 4'h0;
  localparam logic [3:0]  OFS_FACTOR   = 4'h1;
  localparam logic [3:0]  OFS_DIR      = 4'h2;
  localparam logic [3:0]  OFS_DOFN     = 4'h3;
  localparam logic [3:0]  OFS_CTRL     = 4'h4;
  localparam logic [3:0]  OFS_HOLD     = 4'h5;
  localparam logic [3:0]  OFS_STATUS   = 4'h6;
  localparam logic [3:0]  OFS_IRQ_ST   = 4'h7;
  localparam logic [3:0]  OFS_IRQ_EN   = 4'h8;
  localparam logic [3:0]  OFS_IRQ_CLR  = 4'h9;
  // control register fields
  localparam int unsigned CTRL_FCL     = 0;
  localparam int unsigned CTRL_GP1     = 1;
  localparam int unsigned CTRL_GP2     = 2;
  localparam int unsigned CTRL_RESTART = 3;
  // interrupt status fields
  localparam int unsigned IRQ_CMP      = 0;
  localparam int unsigned IRQ_NEAR     = 1;
  localparam int unsigned IRQ_ZPULSE   = 2;
  localparam int unsigned IRQ_OVF      = 3;
  // reset values
  localparam logic [15:0] SOURCE_RST   = 16'h0000;
  localparam logic [15:0] FACTOR_RST   = 16'h0001;
  localparam logic [15:0] DIR_RST      = 16'h0000;
  localparam logic [15:0] DOFN_RST     = 16'h0000;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] HOLD_RST     = 16'h000A;
  // timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned OC_MAX_HZ    = 3000;
  localparam int unsigned OC_STEP_CYC  = (CLK_HZ + 4 * OC_MAX_HZ - 1) / (4 * OC_MAX_HZ);
  localparam int unsigned Z_PULSE_MS   = 5;
  localparam int unsigned MS_CYC       = CLK_HZ / 1000;
  localparam int unsigned Z_PULSE_CYC  = MS_CYC * Z_PULSE_MS;
  localparam int unsigned ENC_CPR      = 131072;

  typedef enum logic [1:0] {
    SRC_MOTOR = 2'b00,
    SRC_CMD   = 2'b01,
    SRC_NONE  = 2'b10
  } epdo_src_t;

  typedef enum logic [1:0] {
    DOFN_GP = 2'b00,
    DOFN_AB = 2'b01,
    DOFN_Z  = 2'b10
  } epdo_dofn_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } epdo_bus_req_t;

  typedef struct packed {
    epdo_src_t         src;
    logic [DATA_W-1:0] factor;
    logic              dir;
    logic              fcl;
  } epdo_cfg_t;

  // one gray step of a quadrature pair: 00 01 11 10 is forward
  function automatic logic [1:0] quad_next(input logic [1:0] ph, input logic up);
    logic [1:0] r;
    r = ph;
    case ({up, ph})
      3'b100:  r = 2'b01;
      3'b101:  r = 2'b11;
      3'b111:  r = 2'b10;
      3'b110:  r = 2'b00;
      3'b000:  r = 2'b10;
      3'b010:  r = 2'b11;
      3'b011:  r = 2'b01;
      3'b001:  r = 2'b00;
      default: r = ph;
    endcase
    return r;
  endfunction : quad_next
endpackage : epdo_pkg

// *** core/epdo_top.sv ***
// Purpose: encoder pulse division output, open-collector and differential paths
// Assumes: pin inputs synchronous to ref_clk; position band inputs come from the loop
// Notes: source, factor, direction take effect only at restart
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module epdo_top #(
  parameter int unsigned OC_STEP_CYC = epdo_pkg::OC_STEP_CYC,
  parameter int unsigned Z_PULSE_CYC = epdo_pkg::Z_PULSE_CYC,
  parameter int unsigned MS_CYC      = epdo_pkg::MS_CYC,
  parameter int unsigned ENC_CPR     = epdo_pkg::ENC_CPR
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire epdo_pkg::epdo_bus_req_t       bus_req,
  output logic [epdo_pkg::DATA_W-1:0]        bus_rdata,
  input  wire logic                          enc_a,
  input  wire logic                          enc_b,
  input  wire logic                          enc_z,
  input  wire logic                          enc_absolute,
  input  wire logic                          cmd_a,
  input  wire logic                          cmd_b,
  input  wire logic                          in_complete_band,
  input  wire logic                          in_near_band,
  output logic                               digital_out_first,
  output logic                               digital_out_second,
  output logic                               diff_a,
  output logic                               diff_b,
  output logic                               diff_z,
  output logic                               diff_oe,
  output logic                               positioning_complete_flag,
  output logic                               positioning_near_flag,
  output logic                               irq
);
  localparam int unsigned DW = epdo_pkg::DATA_W;
  localparam int unsigned TW = epdo_pkg::TMR_W;
  localparam int unsigned AW = epdo_pkg::ACC_W;

  typedef struct packed {
    logic [DW-1:0]            src_sh;
    logic [DW-1:0]            fac_sh;
    logic [DW-1:0]            dir_sh;
    logic [DW-1:0]            dofn;
    logic [DW-1:0]            ctrl;
    logic [DW-1:0]            hold;
    epdo_pkg::epdo_cfg_t      act;
    logic                     load_req;
    logic [1:0]               enc_q;
    logic                     z_q;
    logic [AW-1:0]            acc;
    logic [1:0]               diff_ph;
    logic                     diff_a;
    logic                     diff_b;
    logic                     diff_z;
    logic                     diff_oe;
    logic signed [DW-1:0]     backlog;
    logic [TW-1:0]            gap;
    logic [1:0]               oc_ph;
    logic [TW-1:0]            ztmr;
    logic                     do1;
    logic                     do2;
    logic [TW-1:0]            ms_cnt;
    logic [DW-1:0]            cnt_cmp;
    logic [DW-1:0]            cnt_near;
    logic                     cmp;
    logic                     near;
    logic [epdo_pkg::IRQ_W-1:0] irq_st;
    logic [epdo_pkg::IRQ_W-1:0] irq_en;
    logic [DW-1:0]            rdata;
  } epdo_state_t;

  epdo_state_t st_reg;
  epdo_state_t st_next;
  logic [1:0]  rst_sync;
  logic        rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync[1];

  function automatic logic [TW-1:0] tw(input int unsigned v);
    return TW'(v);
  endfunction : tw

  // free-running tick: hold+1 ticks are needed before hold ms have surely passed
  function automatic logic band_held(input logic [DW-1:0] cnt, input logic [DW-1:0] hold);
    return (hold == '0) || (cnt > hold);
  endfunction : band_held

  always_comb begin
    logic [1:0]  enc_now;
    logic        ev;
    logic        up;
    logic        out_ev;
    logic        out_up;
    logic [AW-1:0] m;
    logic [AW-1:0] s;
    logic [AW-1:0] sum;
    logic [epdo_pkg::IRQ_W-1:0] set_v;
    logic [epdo_pkg::IRQ_W-1:0] clr_v;
    logic        ms_tick;
    st_next = st_reg;
    enc_now = {enc_a, enc_b};
    set_v   = '0;
    clr_v   = '0;
    out_ev  = 1'b0;
    out_up  = 1'b0;
    ev      = 1'b0;
    up      = 1'b0;
    m       = '0;
    s       = '0;
    sum     = '0;
    ms_tick = 1'b0;
    // one-cycle request; a restart written during a load is kept
    st_next.load_req = 1'b0;
    // register port writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        epdo_pkg::OFS_SOURCE:  st_next.src_sh = bus_req.wdata;
        epdo_pkg::OFS_FACTOR:  st_next.fac_sh = bus_req.wdata;
        epdo_pkg::OFS_DIR:     st_next.dir_sh = bus_req.wdata;
        epdo_pkg::OFS_DOFN:    st_next.dofn   = bus_req.wdata;
        epdo_pkg::OFS_CTRL: begin
          st_next.ctrl = bus_req.wdata & ~(DW'(1) << epdo_pkg::CTRL_RESTART);
          if (bus_req.wdata[epdo_pkg::CTRL_RESTART]) begin
            st_next.load_req = 1'b1;
          end
        end
        epdo_pkg::OFS_HOLD:    st_next.hold   = bus_req.wdata;
        epdo_pkg::OFS_IRQ_EN:  st_next.irq_en = bus_req.wdata[epdo_pkg::IRQ_W-1:0];
        epdo_pkg::OFS_IRQ_CLR: clr_v          = bus_req.wdata[epdo_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // reset-valid settings are copied in only at restart
    if (st_reg.load_req) begin
      st_next.act.src    = (st_reg.src_sh > 16'h0002) ? epdo_pkg::SRC_NONE
                         : epdo_pkg::epdo_src_t'(st_reg.src_sh[1:0]);
      st_next.act.factor = (st_reg.fac_sh == 16'h0000) ? 16'h0001 : st_reg.fac_sh;
      st_next.act.dir    = st_reg.dir_sh[0];
      st_next.act.fcl    = st_reg.ctrl[epdo_pkg::CTRL_FCL];
    end
    // encoder quadrature decode; direction bit flips motor pulses only
    st_next.enc_q = enc_now;
    ev = (enc_now != st_reg.enc_q) && (enc_now != ~st_reg.enc_q);
    up = (epdo_pkg::quad_next(st_reg.enc_q, 1'b1) == enc_now) ^ st_reg.act.dir;
    // modulo divider: incremental steps 1 mod factor, absolute steps factor mod cpr
    if (enc_absolute) begin
      m = AW'(ENC_CPR);
      s = AW'(st_reg.act.factor);
    end else begin
      m = AW'(st_reg.act.factor);
      s = AW'(1);
    end
    sum = st_reg.acc + s;
    if (ev && up) begin
      if (sum >= m) begin
        st_next.acc = sum - m;
        out_ev      = 1'b1;
        out_up      = 1'b1;
      end else begin
        st_next.acc = sum;
      end
    end else if (ev) begin
      if (st_reg.acc < s) begin
        st_next.acc = st_reg.acc + m - s;
        out_ev      = 1'b1;
      end else begin
        st_next.acc = st_reg.acc - s;
      end
    end
    // a restart drops the remainder left by the old factor
    if (st_reg.load_req) begin
      st_next.acc = '0;
    end
    // differential path
    st_next.z_q = enc_z;
    if (out_ev) begin
      st_next.diff_ph = epdo_pkg::quad_next(st_reg.diff_ph, out_up);
    end
    case (st_reg.act.src)
      epdo_pkg::SRC_MOTOR: begin
        st_next.diff_a = st_next.diff_ph[1];
        st_next.diff_b = st_next.diff_ph[0];
        st_next.diff_z = enc_z;
      end
      epdo_pkg::SRC_CMD: begin
        st_next.diff_a = cmd_a;
        st_next.diff_b = cmd_b;
        st_next.diff_z = 1'b0;
      end
      default: begin
        st_next.diff_a = 1'b0;
        st_next.diff_b = 1'b0;
        st_next.diff_z = 1'b0;
      end
    endcase
    st_next.diff_oe = (st_reg.act.src != epdo_pkg::SRC_NONE) && !st_reg.act.fcl;
    // open-collector path: backlog drained at the rate limit
    if (out_ev) begin
      if (out_up && st_reg.backlog != 16'sh7FFF) begin
        st_next.backlog = st_reg.backlog + 16'sh0001;
      end else if (!out_up && st_reg.backlog != -16'sh7FFF) begin
        st_next.backlog = st_reg.backlog - 16'sh0001;
      end else begin
        set_v[epdo_pkg::IRQ_OVF] = 1'b1;
      end
    end
    if (st_reg.gap != '0) begin
      st_next.gap = st_reg.gap - tw(1);
    end else if (st_next.backlog != 16'sh0000) begin
      st_next.gap = tw(OC_STEP_CYC - 1);
      st_next.oc_ph = epdo_pkg::quad_next(st_reg.oc_ph, !st_next.backlog[DW-1]);
      st_next.backlog = st_next.backlog[DW-1] ? st_next.backlog + 16'sh0001
                                              : st_next.backlog - 16'sh0001;
    end
    // z stretch on first output
    if (enc_z && !st_reg.z_q) begin
      st_next.ztmr = tw(Z_PULSE_CYC);
      set_v[epdo_pkg::IRQ_ZPULSE] = 1'b1;
    end else if (st_reg.ztmr != '0) begin
      st_next.ztmr = st_reg.ztmr - tw(1);
    end
    // output function select acts at once
    case (st_reg.dofn[1:0])
      epdo_pkg::DOFN_AB: begin
        st_next.do1 = st_next.oc_ph[1];
        st_next.do2 = st_next.oc_ph[0];
      end
      epdo_pkg::DOFN_Z: begin
        st_next.do1 = (st_next.ztmr != '0);
        st_next.do2 = st_reg.ctrl[epdo_pkg::CTRL_GP2];
      end
      default: begin
        st_next.do1 = st_reg.ctrl[epdo_pkg::CTRL_GP1];
        st_next.do2 = st_reg.ctrl[epdo_pkg::CTRL_GP2];
      end
    endcase
    // positioning flags with millisecond hold
    ms_tick = (st_reg.ms_cnt == tw(MS_CYC - 1));
    st_next.ms_cnt = ms_tick ? '0 : st_reg.ms_cnt + tw(1);
    if (!in_complete_band) begin
      st_next.cnt_cmp = '0;
    end else if (ms_tick && st_reg.cnt_cmp <= st_reg.hold) begin
      st_next.cnt_cmp = st_reg.cnt_cmp + 16'h0001;
    end
    if (!in_near_band) begin
      st_next.cnt_near = '0;
    end else if (ms_tick && st_reg.cnt_near <= st_reg.hold) begin
      st_next.cnt_near = st_reg.cnt_near + 16'h0001;
    end
    st_next.cmp  = in_complete_band && band_held(st_next.cnt_cmp, st_reg.hold);
    st_next.near = in_near_band && band_held(st_next.cnt_near, st_reg.hold);
    set_v[epdo_pkg::IRQ_CMP]  = st_next.cmp && !st_reg.cmp;
    set_v[epdo_pkg::IRQ_NEAR] = st_next.near && !st_reg.near;
    // sticky status: a set in the clearing cycle survives
    st_next.irq_st = (st_reg.irq_st & ~clr_v) | set_v;
    // read data, valid the cycle after the strobe
    st_next.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        epdo_pkg::OFS_SOURCE: st_next.rdata = st_reg.src_sh;
        epdo_pkg::OFS_FACTOR: st_next.rdata = st_reg.fac_sh;
        epdo_pkg::OFS_DIR:    st_next.rdata = st_reg.dir_sh;
        epdo_pkg::OFS_DOFN:   st_next.rdata = st_reg.dofn;
        epdo_pkg::OFS_CTRL:   st_next.rdata = st_reg.ctrl;
        epdo_pkg::OFS_HOLD:   st_next.rdata = st_reg.hold;
        epdo_pkg::OFS_STATUS: st_next.rdata = {8'h00, st_reg.act.fcl, st_reg.act.dir,
                                               st_reg.act.src, st_reg.diff_oe,
                                               (st_reg.ztmr != '0), st_reg.near, st_reg.cmp};
        epdo_pkg::OFS_IRQ_ST: st_next.rdata = DW'(st_reg.irq_st);
        epdo_pkg::OFS_IRQ_EN: st_next.rdata = DW'(st_reg.irq_en);
        default:              st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg          <= '0;
      st_reg.src_sh   <= epdo_pkg::SOURCE_RST;
      st_reg.fac_sh   <= epdo_pkg::FACTOR_RST;
      st_reg.dir_sh   <= epdo_pkg::DIR_RST;
      st_reg.dofn     <= epdo_pkg::DOFN_RST;
      st_reg.ctrl     <= epdo_pkg::CTRL_RST;
      st_reg.hold     <= epdo_pkg::HOLD_RST;
      st_reg.act.factor <= epdo_pkg::FACTOR_RST;
      st_reg.load_req <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata                 = st_reg.rdata;
  assign digital_out_first         = st_reg.do1;
  assign digital_out_second        = st_reg.do2;
  assign diff_a                    = st_reg.diff_a;
  assign diff_b                    = st_reg.diff_b;
  assign diff_z                    = st_reg.diff_z;
  assign diff_oe                   = st_reg.diff_oe;
  assign positioning_complete_flag = st_reg.cmp;
  assign positioning_near_flag     = st_reg.near;
  assign irq                       = |(st_reg.irq_st & st_reg.irq_en);

  property p_fcl_blocks_diff;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      st_reg.act.fcl |=> !diff_oe;
  endproperty
  a_fcl_blocks_diff: assert property (p_fcl_blocks_diff) else $error("diff driven in closed loop");

  property p_none_src_input;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (st_reg.act.src == epdo_pkg::SRC_NONE) |=> !diff_oe;
  endproperty
  a_none_src_input: assert property (p_none_src_input) else $error("diff driven with no source");

  property p_cmd_pass;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (st_reg.act.src == epdo_pkg::SRC_CMD) && $stable(st_reg.act.src)
        |-> diff_a == $past(cmd_a) && diff_b == $past(cmd_b);
  endproperty
  a_cmd_pass: assert property (p_cmd_pass) else $error("command pulse not passed");

  property p_oc_rate;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      $changed(st_reg.oc_ph) |-> st_reg.gap == tw(OC_STEP_CYC - 1) && $past(st_reg.gap) == '0;
  endproperty
  a_oc_rate: assert property (p_oc_rate) else $error("open collector step too early");

  property p_quad_gray;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      $changed(st_reg.diff_ph) |-> $onehot(st_reg.diff_ph ^ $past(st_reg.diff_ph));
  endproperty
  a_quad_gray: assert property (p_quad_gray) else $error("quadrature skipped a state");

  property p_ab_mode;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (st_reg.dofn[1:0] == epdo_pkg::DOFN_AB) ##1 (st_reg.dofn[1:0] == epdo_pkg::DOFN_AB)
        |-> digital_out_first == st_reg.oc_ph[1] && digital_out_second == st_reg.oc_ph[0];
  endproperty
  a_ab_mode: assert property (p_ab_mode) else $error("A/B not on digital outputs");

  property p_z_width;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      $rose(st_reg.ztmr != '0) && (st_reg.dofn[1:0] == epdo_pkg::DOFN_Z)
        ##1 (st_reg.dofn[1:0] == epdo_pkg::DOFN_Z)
        |-> digital_out_first && st_reg.ztmr == tw(Z_PULSE_CYC - 1);
  endproperty
  a_z_width: assert property (p_z_width) else $error("z pulse width wrong");

  property p_cmp_cond;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      positioning_complete_flag |-> $past(in_complete_band) &&
        ($past(st_reg.hold) == '0 || st_reg.cnt_cmp > $past(st_reg.hold));
  endproperty
  a_cmp_cond: assert property (p_cmp_cond) else $error("complete without condition");

  property p_near_cond;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      positioning_near_flag |-> $past(in_near_band) &&
        ($past(st_reg.hold) == '0 || st_reg.cnt_near > $past(st_reg.hold));
  endproperty
  a_near_cond: assert property (p_near_cond) else $error("near without condition");

  property p_factor_one;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      !enc_absolute && st_reg.act.factor == 16'h0001 && $stable(st_reg.act.factor)
        |-> st_reg.acc == '0;
  endproperty
  a_factor_one: assert property (p_factor_one) else $error("factor one must not accumulate");
endmodule : epdo_top

`default_nettype wire

// *** bench/epdo_ctrl_model.sv ***
// Purpose: far-side motion controller counting a repeated quadrature pair
// Assumes: pair levels are sampled on the core clock
// Notes: a double jump is dropped, as a real counter would lose it
`timescale 1ns/100ps
`default_nettype none
module epdo_ctrl_model (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              a,
  input  wire logic              b,
  output var  logic signed [15:0] count
);
  logic [1:0] prev_reg;
  // forward order 00 01 11 10
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 2'h0;
      count    <= 16'sh0;
    end else begin
      prev_reg <= {a, b};
      case ({prev_reg, a, b})
        4'h1, 4'h7, 4'hE, 4'h8: count <= count + 16'sh1;
        4'h2, 4'hB, 4'hD, 4'h4: count <= count - 16'sh1;
        default:                count <= count;
      endcase
    end
  end
endmodule : epdo_ctrl_model
`default_nettype wire

// *** bench/epdo_tb_top.sv ***
// Purpose: self-checking bench of the encoder pulse divider output
// Assumes: shortened timing parameters; strobes driven right after rising edges
// Notes: register cases run from a table, pulse paths are hand-written
`timescale 1ns/100ps
`default_nettype none
module epdo_tb_top;
  localparam int unsigned STEP = 4;
  localparam int unsigned ZCYC = 8;
  localparam logic [1:0] GRAY [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  typedef struct packed {logic w; logic [3:0] a; logic [15:0] d; logic [15:0] e;} epdo_row_t;
  localparam epdo_row_t ROWS [9] = '{
    '{1'b0, 4'h0, 16'h0000, 16'h0000}, '{1'b0, 4'h1, 16'h0000, 16'h0001},
    '{1'b0, 4'h2, 16'h0000, 16'h0000}, '{1'b0, 4'h3, 16'h0000, 16'h0000},
    '{1'b0, 4'h5, 16'h0000, 16'h000A}, '{1'b1, 4'h3, 16'h0002, 16'h0002},
    '{1'b1, 4'hF, 16'hFFFF, 16'h0000}, '{1'b1, 4'h9, 16'h000F, 16'h0000},
    '{1'b1, 4'h1, 16'h0003, 16'h0003}};
  logic                    ref_clk = 1'b0;
  logic                    rst_n   = 1'b0;
  epdo_pkg::epdo_bus_req_t bus_req = '0;
  logic [15:0]             bus_rdata;
  logic [1:0]              enc = 2'h0;
  logic [1:0]              cmd = 2'h0;
  logic [1:0]              band = 2'h0;
  logic                    enc_z = 1'b0;
  logic                    enc_abs = 1'b0;
  logic                    do1, do2, da, db, dz, doe, pc, pn, irq;
  logic signed [15:0]      oc_cnt, df_cnt, oc0, df0;
  logic [1:0]              last_oc = 2'h0;
  logic [15:0]             v;
  int                      miscompares = 0;
  int                      n_checks = 0;
  int                      ph = 0;
  int                      cph = 0;
  int                      gap = 0;
  int                      cyc = 0;
  int                      n;
  bit                      ab_on = 1'b0;

  always #5 ref_clk = ~ref_clk;

  epdo_top #(.OC_STEP_CYC(STEP), .Z_PULSE_CYC(ZCYC), .MS_CYC(10), .ENC_CPR(16)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .enc_a(enc[1]), .enc_b(enc[0]), .enc_z(enc_z), .enc_absolute(enc_abs),
    .cmd_a(cmd[1]), .cmd_b(cmd[0]), .in_complete_band(band[1]), .in_near_band(band[0]),
    .digital_out_first(do1), .digital_out_second(do2), .diff_a(da), .diff_b(db),
    .diff_z(dz), .diff_oe(doe), .positioning_complete_flag(pc),
    .positioning_near_flag(pn), .irq(irq));
  epdo_ctrl_model u_oc (.clk(ref_clk), .rst_n(rst_n), .a(do1), .b(do2), .count(oc_cnt));
  epdo_ctrl_model u_df (.clk(ref_clk), .rst_n(rst_n), .a(da), .b(db), .count(df_cnt));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask : rd

  // restart loads the shadow set, so every source, factor or direction change goes through here
  task automatic cfg(input logic [15:0] src, input logic [15:0] fac, input logic [15:0] dir,
                     input logic [15:0] ctl);
    wr(4'h0, src);
    wr(4'h1, fac);
    wr(4'h2, dir);
    wr(4'h4, ctl | 16'h0008);
    repeat (3) @(posedge ref_clk);
    #1 oc0 = oc_cnt;
    df0 = df_cnt;
  endtask : cfg

  task automatic run(input int steps, input int pause, input bit on_cmd);
    repeat (steps) begin
      @(posedge ref_clk);
      if (on_cmd) begin
        cph = (cph + 1) % 4;
        cmd <= GRAY[cph];
      end else begin
        ph = (ph + 1) % 4;
        enc <= GRAY[ph];
      end
      repeat (pause) @(posedge ref_clk);
    end
    // backlog drains at one step per STEP cycles
    repeat (80) @(posedge ref_clk);
  endtask : run

  task automatic cnt(input logic [15:0] e_oc, input logic [15:0] e_df);
    #1 chk("oc count", oc_cnt - oc0, e_oc);
    chk("diff count", df_cnt - df0, e_df);
  endtask : cnt

  always @(posedge ref_clk) begin
    if (ab_on && {do1, do2} !== last_oc) begin
      chk("oc step gap ok", 16'(gap >= STEP), 16'h0001);
      gap = 0;
    end
    last_oc = {do1, do2};
    gap++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    #1 chk("outputs in reset", 16'({do1, do2, doe, pc, pn, irq}), 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (ROWS[i]) begin
      if (ROWS[i].w)
        wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      chk("register", v, ROWS[i].e);
    end
    $display("test registers done");
    wr(4'h3, 16'h0001);
    ab_on = 1'b1;
    cfg(16'h0000, 16'h0001, 16'h0000, 16'h0000);
    chk("diff enable", 16'(doe), 16'h0001);
    @(posedge ref_clk);
    ph = 1;
    enc <= GRAY[1];
    @(posedge ref_clk);
    #1 chk("diff pair", 16'({da, db}), 16'h0001);
    run(7, 0, 1'b0);
    cnt(16'h0008, 16'h0008);
    cfg(16'h0000, 16'h0002, 16'h0000, 16'h0000);
    run(8, 5, 1'b0);
    cnt(16'h0004, 16'h0004);
    cfg(16'h0000, 16'h0001, 16'h0001, 16'h0000);
    run(4, 5, 1'b0);
    cnt(16'hFFFC, 16'hFFFC);
    cfg(16'h0001, 16'h0002, 16'h0001, 16'h0000);
    run(4, 5, 1'b1);
    cnt(16'h0000, 16'h0004);
    enc_abs <= 1'b1;
    cfg(16'h0000, 16'h0004, 16'h0000, 16'h0000);
    run(16, 5, 1'b0);
    cnt(16'h0004, 16'h0004);
    enc_abs <= 1'b0;
    cfg(16'h0002, 16'h0001, 16'h0000, 16'h0000);
    chk("diff enable src2", 16'(doe), 16'h0000);
    rd(4'h6, v);
    chk("status src2", v, 16'h0020);
    cfg(16'h0000, 16'h0001, 16'h0000, 16'h0001);
    chk("diff enable fcl", 16'(doe), 16'h0000);
    rd(4'h6, v);
    chk("status fcl", v, 16'h0080);
    cfg(16'h0000, 16'h0001, 16'h0000, 16'h0000);
    $display("test pulse paths done");
    ab_on = 1'b0;
    wr(4'h3, 16'h0002);
    @(posedge ref_clk);
    enc_z <= 1'b1;
    @(posedge ref_clk);
    #1 chk("diff z", 16'(dz), 16'h0001);
    n = 0;
    for (int i = 0; i < 4 && do1 !== 1'b1; i++)
      @(posedge ref_clk) #1;
    while (do1 === 1'b1 && n < 40) begin
      n++;
      @(posedge ref_clk) #1;
    end
    enc_z <= 1'b0;
    chk("z width", 16'(n), 16'(ZCYC));
    wr(4'h3, 16'h0000);
    wr(4'h4, 16'h0006);
    repeat (3) @(posedge ref_clk);
    #1 chk("plain outputs", 16'({do1, do2}), 16'h0003);
    $display("test z and plain done");
    wr(4'h5, 16'h0002);
    wr(4'h8, 16'h0000);
    band <= 2'h3;
    repeat (20) @(posedge ref_clk);
    #1 chk("flags early", 16'({pc, pn}), 16'h0000);
    repeat (15) @(posedge ref_clk);
    #1 chk("flags held", 16'({pc, pn}), 16'h0003);
    chk("irq masked", 16'(irq), 16'h0000);
    wr(4'h8, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq raised", 16'(irq), 16'h0001);
    rd(4'h7, v);
    chk("irq status", v & 16'h0003, 16'h0003);
    wr(4'h9, 16'h000F);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq cleared", 16'(irq), 16'h0000);
    band <= 2'h0;
    repeat (3) @(posedge ref_clk);
    #1 chk("flags drop", 16'({pc, pn}), 16'h0000);
    $display("test positioning done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1 chk("outputs in reset again", 16'({do1, do2, da, db, dz, doe, pc, pn, irq}), 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(4'h4, v);
    chk("ctrl after reset", v, 16'h0000);
    rd(4'h5, v);
    chk("hold after reset", v, 16'h000A);
    $display("test reset done");
    finish_test();
  end
endmodule : epdo_tb_top
`default_nettype wire
